// *** include/txc_pkg.sv ***
// Constants, types and field layout of the transmit abort and retry control
// Operation
// - Busy line by default abandons packet, no retry
// - Retry-on-busy retries to limit, then failed
// - Hard reset still aborts; enabled cable reset aborts cable-plug packets
// - Good new matching packet aborts pending transmission
// - Software abort request always cancels pending packet
// - SOP aborts non-SOP unless same-type-only set
// - Soft reset ack ignores busy with auto-response on, unless disabled
// - Disable bit lets wait-idle govern ack
// - Wait-for-idle holds packet until line quiet
// - Wait-for-idle outranks retry-on-busy
// - Auto-response bit enables GoodCRC, BIST replies
// - Auto-response off means no hardware retries
// - Bit 1 selects buffer or FIFO loading
// - Bit 0 selects automatic or raw processing
// - Retry limit zero disables hardware retry
package txc_pkg;
   // Register map
   localparam logic [15:0] TXC_CTL_A_ADDR = 16'h1a00;
   localparam logic [7:0] TXC_CTL_A_RST = 8'h00;
   localparam logic [7:0] TXC_CTL_A_WMASK = 8'h7f;
   localparam logic [7:0] TXC_RDATA_IDLE = 8'h00;
   // Field positions of transmit_control_a
   localparam int TXC_BIT_RETRY_BUSY = 6;
   localparam int TXC_BIT_SAME_ONLY = 5;
   localparam int TXC_BIT_SR_SPCL_OFF = 4;
   localparam int TXC_BIT_WAIT_IDLE = 3;
   localparam int TXC_BIT_AUTO_RSP = 2;
   localparam int TXC_BIT_FIFO_LOAD = 1;
   localparam int TXC_BIT_RAW = 0;
   // Start-of-packet codes
   localparam logic [2:0] TXC_SOP = 3'h0;
   localparam logic [2:0] TXC_SOP_P = 3'h1;
   localparam logic [2:0] TXC_SOP_PP = 3'h2;
   localparam logic [2:0] TXC_SOP_P_DBG = 3'h3;
   localparam logic [2:0] TXC_SOP_PP_DBG = 3'h4;
   // Counters and queue shape
   localparam logic [2:0] TXC_TRIES_RST = 3'h0;
   localparam logic [2:0] TXC_TRIES_ONE = 3'h1;
   localparam int TXC_Q_WIDTH = 8;
   localparam int TXC_Q_DEPTH = 32;
   // Transmit sequencer states
   typedef enum logic [1:0] {
      TXC_ST_IDLE,
      TXC_ST_ARB,
      TXC_ST_SEND,
      TXC_ST_ACK
   } txc_state_e;
endpackage

// *** include/txc_stream_if.sv ***
// Valid/ready byte stream between the queue and the sequencer
`timescale 1ns/1ns
interface txc_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** hw/txc_abort_match.sv ***
// Decides whether a pending transmission must be abandoned this cycle
`timescale 1ns/1ns
module txc_abort_match
   import txc_pkg::*;
(
   // Receive events
   input wire logic rx_good,
   input wire logic rx_dup,
   input wire logic rx_ping,
   input wire logic rx_goodcrc,
   input wire logic [2:0] rx_sop,
   input wire logic rx_hard_reset,
   input wire logic rx_cable_reset,
   // Policy and pending packet
   input wire logic cable_reset_en,
   input wire logic sw_abort,
   input wire logic same_only,
   input wire logic [2:0] pend_sop,
   // Decision
   output logic abort_now
);
   logic fresh;
   logic sop_hit;
   logic cable_hit;

   // Packet that counts as new traffic, soft reset included
   assign fresh = rx_good && !rx_dup && !rx_ping && !rx_goodcrc;
   // Same type, or SOP over a non-SOP pending packet
   assign sop_hit = (rx_sop == pend_sop) ||
      (rx_sop == TXC_SOP && pend_sop != TXC_SOP && !same_only);
   // Cable reset only hits the cable-plug variants
   assign cable_hit = rx_cable_reset && cable_reset_en &&
      pend_sop >= TXC_SOP_P && pend_sop <= TXC_SOP_PP_DBG;
   // Any abort source wins over the busy policy
   assign abort_now = rx_hard_reset || cable_hit || (fresh && sop_hit) ||
      sw_abort;
endmodule

// *** hw/txc_queue.sv ***
// Transmit queue FIFO with registered output word
`timescale 1ns/1ns
module txc_queue #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Control
   input wire logic flush,
   // Streams
   txc_stream_if.snk wr,
   txc_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic in_rdy;
      logic ov;
      logic [W-1:0] od;
   } txc_q_s;

   txc_q_s s_r;
   txc_q_s s_nxt;
   logic push;
   logic pop;

   assign wr.ready = s_r.in_rdy;
   assign rd.valid = s_r.ov;
   assign rd.data = s_r.od;

   // Storage, pointers and output stage
   always_comb begin
      s_nxt = s_r;
      push = wr.valid && s_r.in_rdy;
      pop = (s_r.cnt != '0) && (!s_r.ov || rd.ready);
      if (rd.ready) begin
         s_nxt.ov = 1'b0;
      end
      if (pop) begin
         s_nxt.od = s_r.mem[s_r.rp];
         s_nxt.ov = 1'b1;
         s_nxt.rp = s_r.rp + PTR_ONE;
      end
      if (push) begin
         s_nxt.mem[s_r.wp] = wr.data;
         s_nxt.wp = s_r.wp + PTR_ONE;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
         s_nxt.ov = 1'b0;
      end
      s_nxt.in_rdy = (s_nxt.cnt != FULL); // Honest full, registered
   end

   // State register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
         s_r.in_rdy <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// *** hw/txc_tx_control.sv ***
// Transmit abort, retry and wait-for-idle sequencer with its control register
`timescale 1ns/1ns
module txc_tx_control
   import txc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Transmit request
   input wire logic tx_go,
   input wire logic [2:0] tx_go_sop,
   input wire logic tx_go_sr_ack,
   input wire logic [2:0] retry_limit,
   input wire logic cable_reset_en,
   input wire logic tx_abort_req,
   // Queue write side
   input wire logic q_valid,
   input wire logic [7:0] q_data,
   output logic q_ready,
   // Line side
   input wire logic line_busy,
   output logic phy_valid,
   output logic [7:0] phy_data,
   input wire logic phy_ready,
   input wire logic phy_eop,
   input wire logic ack_ok,
   input wire logic ack_timeout,
   // Receive events
   input wire logic rx_good,
   input wire logic rx_dup,
   input wire logic rx_ping,
   input wire logic rx_goodcrc,
   input wire logic [2:0] rx_sop,
   input wire logic rx_hard_reset,
   input wire logic rx_cable_reset,
   // Status and mode outputs
   output logic tx_active,
   output logic tx_success,
   output logic tx_aborted,
   output logic transmit_failed_flag,
   output logic [2:0] hw_tries,
   output logic auto_response_en,
   output logic queue_fifo_loading_en,
   output logic raw_payload_processing_en
);
   typedef struct packed {
      txc_state_e st;
      logic [7:0] ctl;
      logic [2:0] tries;
      logic [2:0] sop;
      logic sr_ack;
      logic [7:0] rdata;
      logic pv;
      logic [7:0] pd;
      logic active;
      logic ok;
      logic aborted;
      logic failed;
      logic flush;
   } txc_top_s;

   txc_top_s s_r;
   txc_top_s s_nxt;
   txc_stream_if #(.W(TXC_Q_WIDTH)) q_in ();
   txc_stream_if #(.W(TXC_Q_WIDTH)) q_out ();
   logic abort_now;
   logic hit;
   logic busy_retry;
   logic special;
   logic [2:0] eff_limit;

   // Queue write side and drain side
   assign q_in.valid = q_valid;
   assign q_in.data = q_data;
   assign q_ready = q_in.ready;
   assign q_out.ready = (s_r.st == TXC_ST_SEND) && (!s_r.pv || phy_ready);

   txc_queue #(
      .W(TXC_Q_WIDTH),
      .DEPTH(TXC_Q_DEPTH)
   ) u_queue (
      .sys_clk(sys_clk),
      .reset(reset),
      .flush(s_r.flush),
      .wr(q_in.snk),
      .rd(q_out.src)
   );

   txc_abort_match u_match (
      .rx_good(rx_good),
      .rx_dup(rx_dup),
      .rx_ping(rx_ping),
      .rx_goodcrc(rx_goodcrc),
      .rx_sop(rx_sop),
      .rx_hard_reset(rx_hard_reset),
      .rx_cable_reset(rx_cable_reset),
      .cable_reset_en(cable_reset_en),
      .sw_abort(tx_abort_req),
      .same_only(s_r.ctl[TXC_BIT_SAME_ONLY]),
      .pend_sop(s_r.sop),
      .abort_now(abort_now)
   );

   // Policy terms
   assign hit = (reg_addr == TXC_CTL_A_ADDR);
   assign eff_limit = s_r.ctl[TXC_BIT_AUTO_RSP] ? retry_limit : TXC_TRIES_RST;
   assign busy_retry = s_r.ctl[TXC_BIT_RETRY_BUSY] && !s_r.ctl[TXC_BIT_WAIT_IDLE];
   assign special = s_r.sr_ack && s_r.ctl[TXC_BIT_AUTO_RSP] &&
      !s_r.ctl[TXC_BIT_SR_SPCL_OFF];

   // Outputs straight from state
   assign reg_rdata = s_r.rdata;
   assign phy_valid = s_r.pv;
   assign phy_data = s_r.pd;
   assign tx_active = s_r.active;
   assign tx_success = s_r.ok;
   assign tx_aborted = s_r.aborted;
   assign transmit_failed_flag = s_r.failed;
   assign hw_tries = s_r.tries;
   assign auto_response_en = s_r.ctl[TXC_BIT_AUTO_RSP];
   assign queue_fifo_loading_en = s_r.ctl[TXC_BIT_FIFO_LOAD];
   assign raw_payload_processing_en = s_r.ctl[TXC_BIT_RAW];

   // Register access, byte pipeline and sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.ok = 1'b0;
      s_nxt.aborted = 1'b0;
      s_nxt.failed = 1'b0;
      s_nxt.flush = 1'b0;
      if (reg_wr && hit) begin
         s_nxt.ctl = reg_wdata & TXC_CTL_A_WMASK;
      end
      s_nxt.rdata = (reg_rd && hit) ? (s_r.ctl & TXC_CTL_A_WMASK) : TXC_RDATA_IDLE;
      if (phy_ready) begin
         s_nxt.pv = 1'b0;
      end
      if (q_out.valid && q_out.ready) begin
         s_nxt.pv = 1'b1;
         s_nxt.pd = q_out.data;
      end
      case (s_r.st)
         TXC_ST_IDLE: begin
            if (tx_go) begin
               s_nxt.st = TXC_ST_ARB;
               s_nxt.sop = tx_go_sop;
               s_nxt.sr_ack = tx_go_sr_ack;
               s_nxt.tries = TXC_TRIES_RST;
               s_nxt.active = 1'b1;
            end
         end
         TXC_ST_ARB: begin
            if (!line_busy || special) begin
               s_nxt.st = TXC_ST_SEND;
            end else if (s_r.ctl[TXC_BIT_WAIT_IDLE]) begin
               s_nxt.st = TXC_ST_ARB;
            end else if (busy_retry && s_r.tries < eff_limit) begin
               s_nxt.tries = s_r.tries + TXC_TRIES_ONE;
            end else if (busy_retry) begin
               s_nxt.st = TXC_ST_IDLE;
               s_nxt.active = 1'b0;
               s_nxt.failed = 1'b1;
               s_nxt.flush = 1'b1;
            end else begin
               s_nxt.st = TXC_ST_IDLE;
               s_nxt.active = 1'b0;
               s_nxt.aborted = 1'b1;
               s_nxt.flush = 1'b1;
            end
         end
         TXC_ST_SEND: begin
            if (phy_eop && s_r.ctl[TXC_BIT_AUTO_RSP]) begin
               s_nxt.st = TXC_ST_ACK;
            end else if (phy_eop) begin
               s_nxt.st = TXC_ST_IDLE;
               s_nxt.active = 1'b0;
               s_nxt.ok = 1'b1;
            end
         end
         TXC_ST_ACK: begin
            if (ack_ok) begin
               s_nxt.st = TXC_ST_IDLE;
               s_nxt.active = 1'b0;
               s_nxt.ok = 1'b1;
            end else if (ack_timeout && s_r.tries < eff_limit) begin
               s_nxt.st = TXC_ST_ARB;
               s_nxt.tries = s_r.tries + TXC_TRIES_ONE;
            end else if (ack_timeout) begin
               s_nxt.st = TXC_ST_IDLE;
               s_nxt.active = 1'b0;
               s_nxt.failed = 1'b1;
               s_nxt.flush = 1'b1;
            end
         end
         default: begin
            s_nxt.st = TXC_ST_IDLE;
            s_nxt.active = 1'b0;
         end
      endcase
      // Abort sources override every policy while a packet is pending
      if (s_r.st != TXC_ST_IDLE && abort_now) begin
         s_nxt.st = TXC_ST_IDLE;
         s_nxt.active = 1'b0;
         s_nxt.ok = 1'b0;
         s_nxt.failed = 1'b0;
         s_nxt.aborted = 1'b1;
         s_nxt.flush = 1'b1;
         s_nxt.pv = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
         s_r.st <= TXC_ST_IDLE;
         s_r.ctl <= TXC_CTL_A_RST;
         s_r.tries <= TXC_TRIES_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Checks on the sequencer
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   logic busy_arb;
   assign busy_arb = s_r.st == TXC_ST_ARB && line_busy && !abort_now && !special;

   property p_default_busy;
      busy_arb && !s_r.ctl[TXC_BIT_RETRY_BUSY] && !s_r.ctl[TXC_BIT_WAIT_IDLE]
         |=> tx_aborted && !tx_active;
   endproperty
   a_default_busy: assert property (p_default_busy)
      else $error("busy line did not abandon packet");

   property p_retry_busy;
      busy_arb && busy_retry && s_r.tries < eff_limit
         |=> s_r.st == TXC_ST_ARB && s_r.tries == $past(s_r.tries) + TXC_TRIES_ONE;
   endproperty
   a_retry_busy: assert property (p_retry_busy)
      else $error("retry on busy did not count");

   property p_retry_exhaust;
      busy_arb && busy_retry && s_r.tries >= eff_limit
         |=> transmit_failed_flag && !tx_aborted;
   endproperty
   a_retry_exhaust: assert property (p_retry_exhaust)
      else $error("exhausted retries not reported failed");

   property p_hard_reset;
      s_r.st != TXC_ST_IDLE && rx_hard_reset |=> tx_aborted ##1 !tx_aborted;
   endproperty
   a_hard_reset: assert property (p_hard_reset)
      else $error("hard reset did not abort");

   property p_sw_abort;
      tx_active && tx_abort_req |=> !tx_active && tx_aborted && !phy_valid;
   endproperty
   a_sw_abort: assert property (p_sw_abort)
      else $error("software abort ignored");

   property p_sop_over_other;
      tx_active && rx_good && !rx_dup && !rx_ping && !rx_goodcrc && rx_sop == TXC_SOP &&
         s_r.sop != TXC_SOP && !s_r.ctl[TXC_BIT_SAME_ONLY] |=> tx_aborted;
   endproperty
   a_sop_over_other: assert property (p_sop_over_other)
      else $error("SOP packet did not abort other type");

   property p_sr_ack;
      s_r.st == TXC_ST_ARB && line_busy && special && !abort_now |=> s_r.st == TXC_ST_SEND;
   endproperty
   a_sr_ack: assert property (p_sr_ack)
      else $error("soft reset ack held by busy line");

   property p_wait_idle;
      busy_arb && s_r.ctl[TXC_BIT_WAIT_IDLE]
         |=> s_r.st == TXC_ST_ARB && s_r.tries == $past(s_r.tries) && tx_active;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("wait for idle did not hold packet");

   property p_no_auto_retry;
      s_r.st == TXC_ST_ACK && ack_timeout && !ack_ok && !abort_now &&
         (!s_r.ctl[TXC_BIT_AUTO_RSP] || retry_limit == TXC_TRIES_RST)
         |=> transmit_failed_flag && s_r.st == TXC_ST_IDLE;
   endproperty
   a_no_auto_retry: assert property (p_no_auto_retry)
      else $error("hardware retried without permission");

   property p_reserved;
      reg_rd && hit |=> reg_rdata[7] == 1'b0 && reg_rdata[6:0] == $past(s_r.ctl[6:0]);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bit read nonzero");

   // Enabled cable reset drops any cable-plug variant
   property p_cable_reset;
      tx_active && rx_cable_reset && cable_reset_en && s_r.sop != TXC_SOP &&
         s_r.sop <= TXC_SOP_PP_DBG |=> tx_aborted && !tx_active;
   endproperty
   a_cable_reset: assert property (p_cable_reset)
      else $error("cable reset did not abort");

   // New traffic of the pending type always cancels
   property p_same_type;
      tx_active && rx_good && !rx_dup && !rx_ping && !rx_goodcrc && rx_sop == s_r.sop
         |=> tx_aborted && !tx_active;
   endproperty
   a_same_type: assert property (p_same_type)
      else $error("matching packet did not abort");
endmodule

// *** verification/txc_far_end.sv ***
// Far-end line model: takes bytes, ends the frame, answers with an ack
`timescale 1ns/1ns
module txc_far_end (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Bench controls
   input wire logic slow,
   input wire logic ack_good,
   input wire logic [5:0] frame_len,
   // Line side
   input wire logic phy_valid,
   input wire logic [7:0] phy_data,
   output logic phy_ready,
   output logic phy_eop,
   output logic ack_ok,
   output logic ack_timeout,
   output logic [7:0] last_byte
);
   logic [5:0] n_r;
   // Byte sink, stalls every other cycle when slow
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         n_r <= 6'h0;
         phy_ready <= 1'h0;
         phy_eop <= 1'h0;
         ack_ok <= 1'h0;
         ack_timeout <= 1'h0;
         last_byte <= 8'h0;
      end else begin
         phy_ready <= slow ? !phy_ready : 1'h1;
         phy_eop <= 1'h0;
         ack_ok <= phy_eop & ack_good;
         ack_timeout <= phy_eop & !ack_good;
         if (phy_valid && phy_ready) begin
            last_byte <= phy_data;
            n_r <= n_r + 6'h1;
            if (n_r + 6'h1 == frame_len) begin
               phy_eop <= 1'h1;
               n_r <= 6'h0;
            end
         end
      end
   end
endmodule

// *** verification/pd_tx_abort_retry_control_tb.sv ***
// Self-checking bench for the transmit abort and retry control
`timescale 1ns/1ns
module pd_tx_abort_retry_control_tb;
   import txc_pkg::*;
   typedef struct packed {
      logic [7:0] ctl;
      logic [2:0] psop;
      logic [3:0] ev;
      logic cen;
      logic [2:0] qual;
      logic [2:0] rsop;
      logic ab;
   } txc_row_s;
   logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, tx_go = 0, tx_go_sr_ack = 0;
   logic cable_reset_en = 0, tx_abort_req = 0, q_valid = 0, line_busy = 0, rx_good = 0;
   logic rx_dup = 0, rx_ping = 0, rx_goodcrc = 0, rx_hard_reset = 0, rx_cable_reset = 0;
   logic slow = 0, ack_good = 1, phy_ready, phy_eop, ack_ok, ack_timeout, q_ready, phy_valid;
   logic tx_active, tx_success, tx_aborted, transmit_failed_flag, auto_response_en;
   logic queue_fifo_loading_en, raw_payload_processing_en;
   logic [15:0] reg_addr = 16'h1a00;
   logic [7:0] reg_wdata = 0, q_data = 0, reg_rdata, phy_data, last_byte, rd, code;
   logic [2:0] tx_go_sop = 0, retry_limit = 0, rx_sop = 0, hw_tries;
   logic [5:0] frame_len = 6'h2;
   logic [7:0] pats[3] = '{8'hff, 8'h2a, 8'h55};
   int err_total = 0, n_tests = 0, got;
   txc_row_s rows[14] = '{
      '{8'h48, 3'h0, 4'h8, 1'h0, 3'h0, 3'h0, 1'h1}, '{8'h08, 3'h1, 4'h4, 1'h1, 3'h0, 3'h0, 1'h1},
      '{8'h08, 3'h4, 4'h4, 1'h1, 3'h0, 3'h0, 1'h1}, '{8'h08, 3'h1, 4'h4, 1'h0, 3'h0, 3'h0, 1'h0},
      '{8'h08, 3'h0, 4'h4, 1'h1, 3'h0, 3'h0, 1'h0}, '{8'h08, 3'h2, 4'h2, 1'h0, 3'h0, 3'h2, 1'h1},
      '{8'h08, 3'h2, 4'h2, 1'h0, 3'h4, 3'h2, 1'h0}, '{8'h08, 3'h2, 4'h2, 1'h0, 3'h2, 3'h2, 1'h0},
      '{8'h08, 3'h2, 4'h2, 1'h0, 3'h1, 3'h2, 1'h0}, '{8'h08, 3'h1, 4'h2, 1'h0, 3'h0, 3'h0, 1'h1},
      '{8'h28, 3'h1, 4'h2, 1'h0, 3'h0, 3'h0, 1'h0}, '{8'h28, 3'h3, 4'h2, 1'h0, 3'h0, 3'h3, 1'h1},
      '{8'h08, 3'h0, 4'h2, 1'h0, 3'h0, 3'h1, 1'h0}, '{8'h48, 3'h3, 4'h1, 1'h0, 3'h0, 3'h0, 1'h1}};
   txc_tx_control txc_tx_control_i (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .tx_go, .tx_go_sop, .tx_go_sr_ack, .retry_limit, .cable_reset_en,
      .tx_abort_req, .q_valid, .q_data, .q_ready, .line_busy, .phy_valid, .phy_data, .phy_ready,
      .phy_eop, .ack_ok, .ack_timeout, .rx_good, .rx_dup, .rx_ping, .rx_goodcrc, .rx_sop,
      .rx_hard_reset, .rx_cable_reset, .tx_active, .tx_success, .tx_aborted,
      .transmit_failed_flag, .hw_tries, .auto_response_en, .queue_fifo_loading_en,
      .raw_payload_processing_en);
   txc_far_end txc_far_end_i (.sys_clk, .reset, .slow, .ack_good, .frame_len, .phy_valid,
      .phy_data, .phy_ready, .phy_eop, .ack_ok, .ack_timeout, .last_byte);
   // Clock
   always #50 sys_clk = !sys_clk;
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] seen);
      n_tests++;
      if (exp !== seen) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge sys_clk);
      reg_wr = 1'h0;
   endtask
   task automatic rdr(logic [15:0] a);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge sys_clk);
      reg_rd = 1'h0;
      rd = reg_rdata;
   endtask
   task automatic push_n(int n);
      got = 0;
      @(negedge sys_clk);
      while (got < n && q_ready === 1'h1) begin
         q_valid = 1'h1;
         q_data = 8'(got + 1);
         got++;
         @(negedge sys_clk);
      end
      q_valid = 1'h0;
   endtask
   task automatic go(logic [2:0] sop, logic sr);
      @(negedge sys_clk);
      tx_go = 1'h1;
      tx_go_sop = sop;
      tx_go_sr_ack = sr;
      @(negedge sys_clk);
      tx_go = 1'h0;
   endtask
   // Outcome code: 1 success, 2 aborted, 3 failed, 0 none
   task automatic wait_end;
      code = 8'h0;
      for (int i = 0; i < 300 && code == 0; i++) begin
         @(negedge sys_clk);
         code = tx_success ? 8'h1 : tx_aborted ? 8'h2 : transmit_failed_flag ? 8'h3 : 8'h0;
      end
   endtask
   task automatic run(logic [7:0] ctl, logic [2:0] lim, logic sr, logic busy,
         logic [7:0] exp, logic [2:0] tries);
      wr(TXC_CTL_A_ADDR, ctl);
      retry_limit = lim;
      push_n(2);
      line_busy = busy;
      go(TXC_SOP, sr);
      wait_end;
      chk("outcome", exp, code);
      chk("tries", {5'h0, tries}, {5'h0, hw_tries});
      line_busy = 1'h0;
   endtask
   // Watchdog
   initial begin
      #2000000;
      err_total++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      repeat (10) @(negedge sys_clk);
      reset = 1'h0;
      rdr(TXC_CTL_A_ADDR);
      chk("reset reg", TXC_CTL_A_RST, rd);
      chk("reset q_ready", 8'h1, {7'h0, q_ready});
      foreach (rows[i]) begin
         wr(TXC_CTL_A_ADDR, rows[i].ctl);
         line_busy = 1'h1;
         cable_reset_en = rows[i].cen;
         go(rows[i].psop, 1'h0);
         repeat (4) @(negedge sys_clk);
         chk("held", 8'h1, {7'h0, tx_active});
         {rx_hard_reset, rx_cable_reset, rx_good, tx_abort_req} = rows[i].ev;
         {rx_dup, rx_ping, rx_goodcrc} = rows[i].qual;
         rx_sop = rows[i].rsop;
         @(negedge sys_clk);
         chk("abort", {7'h0, rows[i].ab}, {7'h0, tx_aborted});
         {rx_hard_reset, rx_cable_reset, rx_good, tx_abort_req} = 4'h0;
         if (!rows[i].ab) begin
            tx_abort_req = 1'h1;
            @(negedge sys_clk);
            tx_abort_req = 1'h0;
            chk("sw abort", 8'h1, {7'h0, tx_aborted});
         end
         line_busy = 1'h0;
      end
      // Register access, reserved bit and unmapped address
      foreach (pats[i]) begin
         wr(TXC_CTL_A_ADDR, pats[i]);
         rdr(TXC_CTL_A_ADDR);
         chk("reg", pats[i] & 8'h7f, rd);
         chk("modes", {5'h0, pats[i][2:0]}, {5'h0, auto_response_en,
            queue_fifo_loading_en, raw_payload_processing_en});
      end
      wr(16'h1a01, 8'h00);
      rdr(16'h1a01);
      chk("unmapped", TXC_RDATA_IDLE, rd);
      rdr(TXC_CTL_A_ADDR);
      chk("kept", 8'h55, rd);
      // Busy-line and acknowledge policies
      run(8'h00, 3'h2, 1'h0, 1'h1, 8'h2, 3'h0);
      run(8'h44, 3'h2, 1'h0, 1'h1, 8'h3, 3'h2);
      run(8'h40, 3'h2, 1'h0, 1'h1, 8'h3, 3'h0);
      run(8'h44, 3'h0, 1'h0, 1'h1, 8'h3, 3'h0);
      run(8'h04, 3'h2, 1'h1, 1'h1, 8'h1, 3'h0);
      run(8'h14, 3'h2, 1'h1, 1'h1, 8'h2, 3'h0);
      ack_good = 1'h0;
      run(8'h04, 3'h0, 1'h0, 1'h0, 8'h3, 3'h0);
      run(8'h00, 3'h2, 1'h0, 1'h0, 8'h1, 3'h0);
      ack_good = 1'h1;
      // Soft reset ack held by wait-for-idle once special treatment is off
      wr(TXC_CTL_A_ADDR, 8'h5c);
      push_n(2);
      line_busy = 1'h1;
      go(TXC_SOP, 1'h1);
      repeat (6) @(negedge sys_clk);
      chk("sr held", 8'h1, {7'h0, tx_active});
      chk("no retry", 8'h0, {5'h0, hw_tries});
      line_busy = 1'h0;
      wait_end;
      chk("sr sent", 8'h1, code);
      // Fill the queue until refused, then drain against a stalling line
      wr(TXC_CTL_A_ADDR, 8'h00);
      push_n(40);
      chk("fill", 8'h21, 8'(got));
      frame_len = 6'h21;
      slow = 1'h1;
      go(TXC_SOP, 1'h0);
      wait_end;
      chk("drain", 8'h1, code);
      chk("last byte", 8'h21, last_byte);
      chk("empty", 8'h1, {7'h0, q_ready});
      // Reset in mid-run drops a held packet and clears the register
      slow = 1'h0;
      wr(TXC_CTL_A_ADDR, 8'h08);
      line_busy = 1'h1;
      go(TXC_SOP_P, 1'h0);
      reset = 1'h1;
      repeat (2) @(negedge sys_clk);
      reset = 1'h0;
      line_busy = 1'h0;
      @(negedge sys_clk);
      chk("reset active", 8'h0, {7'h0, tx_active});
      chk("reset q_ready 2", 8'h1, {7'h0, q_ready});
      rdr(TXC_CTL_A_ADDR);
      chk("reset reg 2", TXC_CTL_A_RST, rd);
      tally_and_finish;
   end
endmodule
